// ===== rtl/host_power_reset_control.v
// Host supply sense, power and reset switch pulser with serial configuration link
//
// Strobed register access and the address map were decided locally.
`include "host_pwr_map.vh"

module host_power_reset_control (
  // Clock and reset
  input  wire        CORE_CLK_I,
  input  wire        ARST_N_I,
  // Register port
  input  wire [7:0]  REG_ADDR_I,
  input  wire [31:0] REG_WDATA_I,
  input  wire        REG_WR_I,
  input  wire        REG_RD_I,
  output reg  [31:0] REG_RDATA_O,
  // Serial host link
  input  wire        SER_RXD_I,
  output reg         SER_TXD_O,
  // Keypad and supply sense
  input  wire        KEY_POWER_I,
  input  wire        KEY_RESET_I,
  input  wire        HOST_PWR_SENSE_I,
  // Host switch lines and display blanking
  output wire        PWR_SW_O,
  output wire        PWR_SW_OE_O,
  output wire        RST_SW_O,
  output wire        RST_SW_OE_O,
  output reg         BLANK_DISPLAY_O
);

  localparam integer BIT_LAST_INT  = `BIT_CYC - 1;
  localparam integer HALF_LAST_INT = `HALF_CYC - 1;
  localparam [10:0]  BIT_LAST      = BIT_LAST_INT[10:0];
  localparam [10:0]  HALF_LAST     = HALF_LAST_INT[10:0];
  localparam [3:0]   SYNC_INIT     = `SYNC_RESET;

  localparam [3:0] RX_IDLE  = 4'b0001;
  localparam [3:0] RX_START = 4'b0010;
  localparam [3:0] RX_BITS  = 4'b0100;
  localparam [3:0] RX_STOP  = 4'b1000;

  localparam [4:0] P_TYPE = 5'b00001;
  localparam [4:0] P_LEN  = 5'b00010;
  localparam [4:0] P_DATA = 5'b00100;
  localparam [4:0] P_CRCL = 5'b01000;
  localparam [4:0] P_CRCH = 5'b10000;

  function [15:0] crc_byte;
    input [15:0] c;
    input [7:0]  d;
    integer      k;
    reg   [15:0] r;
    begin
      r = c ^ {8'h00, d};
      for (k = 0; k < 8; k = k + 1) begin
        r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
      end
      crc_byte = r;
    end
  endfunction

  // ==========================================================================
  // Input synchronisers: {rxd, reset key, power key, sense}
  wire [3:0] raw_in = {SER_RXD_I, KEY_RESET_I, KEY_POWER_I, HOST_PWR_SENSE_I};
  reg  [3:0] sync1;
  reg  [3:0] sync2;
  reg  [3:0] sync3;
  reg  [3:0] clean;
  reg  [3:0] clean_q;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : sync_g
      always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
          sync1[g]   <= SYNC_INIT[g];
          sync2[g]   <= SYNC_INIT[g];
          sync3[g]   <= SYNC_INIT[g];
          clean[g]   <= SYNC_INIT[g];
          clean_q[g] <= SYNC_INIT[g];
        end else begin
          sync1[g]   <= raw_in[g];
          sync2[g]   <= sync1[g];
          sync3[g]   <= sync2[g];
          if (sync2[g] == sync3[g]) begin
            clean[g] <= sync3[g];
          end
          clean_q[g] <= clean[g];
        end
      end
    end
  endgenerate

  wire host_on  = clean[0];
  wire rxd      = clean[3];
  wire kp_rise  = clean[1] & ~clean_q[1];
  wire kr_rise  = clean[2] & ~clean_q[2];

  // ==========================================================================
  // Serial receiver, 8 data bits, no parity, one stop bit
  reg [3:0]  rx_st;
  reg [10:0] rx_cnt;
  reg [2:0]  rx_n;
  reg [7:0]  rx_sh;
  reg        rx_valid;

  always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rx_st    <= RX_IDLE;
      rx_cnt   <= 11'h000;
      rx_n     <= 3'h0;
      rx_sh    <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (rx_cnt != 11'h000) begin
        rx_cnt <= rx_cnt - 11'h001;
      end else begin
        case (rx_st)
          RX_IDLE: begin
            if (!rxd) begin
              rx_st  <= RX_START;
              rx_cnt <= HALF_LAST;
            end
          end
          RX_START: begin
            rx_st  <= rxd ? RX_IDLE : RX_BITS;
            rx_cnt <= BIT_LAST;
            rx_n   <= 3'h0;
          end
          RX_BITS: begin
            rx_sh  <= {rxd, rx_sh[7:1]};
            rx_cnt <= BIT_LAST;
            rx_n   <= rx_n + 3'h1;
            if (rx_n == 3'h7) begin
              rx_st <= RX_STOP;
            end
          end
          RX_STOP: begin
            rx_valid <= rxd;
            rx_st    <= RX_IDLE;
          end
          default: rx_st <= RX_IDLE;
        endcase
      end
    end
  end

  // ==========================================================================
  // Packet parser
  reg [4:0]  p_st;
  reg [7:0]  p_type;
  reg [7:0]  p_len;
  reg [7:0]  p_cnt;
  reg [7:0]  p_d0;
  reg [7:0]  p_crcl;
  reg [15:0] p_crc;
  reg        pkt_done;
  reg        pkt_bad;

  always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      p_st     <= P_TYPE;
      p_type   <= 8'h00;
      p_len    <= 8'h00;
      p_cnt    <= 8'h00;
      p_d0     <= 8'h00;
      p_crcl   <= 8'h00;
      p_crc    <= `CRC_INIT;
      pkt_done <= 1'b0;
      pkt_bad  <= 1'b0;
    end else begin
      pkt_done <= 1'b0;
      pkt_bad  <= 1'b0;
      if (rx_valid) begin
        case (p_st)
          P_TYPE: begin
            p_type <= rx_sh;
            p_crc  <= crc_byte(`CRC_INIT, rx_sh);
            p_st   <= P_LEN;
          end
          P_LEN: begin
            p_len <= rx_sh;
            p_cnt <= 8'h00;
            p_crc <= crc_byte(p_crc, rx_sh);
            if (rx_sh > `MAX_LEN) begin
              p_st    <= P_TYPE;
              pkt_bad <= 1'b1;
            end else begin
              p_st <= (rx_sh == 8'h00) ? P_CRCL : P_DATA;
            end
          end
          P_DATA: begin
            if (p_cnt == 8'h00) begin
              p_d0 <= rx_sh;
            end
            p_cnt <= p_cnt + 8'h01;
            p_crc <= crc_byte(p_crc, rx_sh);
            if (p_cnt + 8'h01 == p_len) begin
              p_st <= P_CRCL;
            end
          end
          P_CRCL: begin
            p_crcl <= rx_sh;
            p_st   <= P_CRCH;
          end
          P_CRCH: begin
            p_st <= P_TYPE;
            if ({rx_sh, p_crcl} == ~p_crc) begin
              pkt_done <= 1'b1;
            end else begin
              pkt_bad <= 1'b1;
            end
          end
          default: p_st <= P_TYPE;
        endcase
      end
    end
  end

  wire [5:0] p_code   = p_type[5:0];
  wire       is_cmd   = p_type[7:6] == `TYPE_CMD;
  wire       do_atx   = is_cmd && p_code == `CMD_ATX && p_len == 8'h01;
  wire       do_store = is_cmd && p_code == `CMD_STORE && p_len == 8'h00;

  // ==========================================================================
  // Answer transmitter: type, zero length, check low, check high
  reg        resp_busy;
  reg [7:0]  resp_type;
  reg [15:0] resp_crc;
  reg [1:0]  resp_idx;
  reg [9:0]  tx_sh;
  reg [3:0]  tx_bits;
  reg [10:0] tx_cnt;
  reg [7:0]  tx_byte;

  always @* begin
    case (resp_idx)
      2'h0:    tx_byte = resp_type;
      2'h1:    tx_byte = 8'h00;
      2'h2:    tx_byte = resp_crc[7:0];
      default: tx_byte = resp_crc[15:8];
    endcase
  end

  wire [7:0] next_resp_type = {(do_atx | do_store) ? `TYPE_RESP : `TYPE_ERR, p_code};

  always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      resp_busy <= 1'b0;
      resp_type <= 8'h00;
      resp_crc  <= 16'h0000;
      resp_idx  <= 2'h0;
      tx_sh     <= 10'h3ff;
      tx_bits   <= 4'h0;
      tx_cnt    <= 11'h000;
      SER_TXD_O <= 1'b1;
    end else begin
      SER_TXD_O <= tx_sh[0];
      if (pkt_done && !resp_busy) begin
        resp_busy <= 1'b1;
        resp_type <= next_resp_type;
        resp_crc  <= ~crc_byte(crc_byte(`CRC_INIT, next_resp_type), 8'h00);
        resp_idx  <= 2'h0;
      end
      if (tx_bits != 4'h0) begin
        if (tx_cnt != 11'h000) begin
          tx_cnt <= tx_cnt - 11'h001;
        end else begin
          tx_sh   <= {1'b1, tx_sh[9:1]};
          tx_bits <= tx_bits - 4'h1;
          tx_cnt  <= BIT_LAST;
        end
      end else if (resp_busy) begin
        tx_sh    <= {1'b1, tx_byte, 1'b0};
        tx_bits  <= 4'ha;
        tx_cnt   <= BIT_LAST;
        resp_idx <= resp_idx + 2'h1;
        if (resp_idx == 2'h3) begin
          resp_busy <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // Registers, watchdog and pulse requests
  reg [7:0]  cfg;
  reg [7:0]  boot_cfg;
  reg [23:0] pulse_len;
  reg [31:0] wdog_cnt;
  reg        link_err;
  reg        sw_pwr;
  reg        sw_rst;
  wire [1:0] busy;

  wire wr_cfg  = REG_WR_I && REG_ADDR_I == `ADDR_CFG;
  wire wr_cmd  = REG_WR_I && REG_ADDR_I == `ADDR_CMD;
  wire wdog_fire = wdog_cnt == 32'h0000_0001;
  wire pwr_req = sw_pwr || (kp_rise && (host_on ? cfg[`CFG_KEY_OFF] : cfg[`CFG_KEY_ON]));
  wire rst_req = sw_rst || wdog_fire || (kr_rise && host_on && cfg[`CFG_KEY_RST]);

  always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      cfg             <= `CFG_RESET;
      boot_cfg        <= `CFG_RESET;
      pulse_len       <= `PULSE_RESET;
      wdog_cnt        <= 32'h0000_0000;
      link_err        <= 1'b0;
      sw_pwr          <= 1'b0;
      sw_rst          <= 1'b0;
      BLANK_DISPLAY_O <= 1'b0;
      REG_RDATA_O     <= 32'h0000_0000;
    end else begin
      if (pkt_done && do_atx) begin
        cfg <= p_d0;
      end else if (wr_cfg) begin
        cfg <= REG_WDATA_I[7:0];
      end
      if (pkt_done && do_store) begin
        boot_cfg <= cfg;
      end
      if (REG_WR_I && REG_ADDR_I == `ADDR_PULSE) begin
        pulse_len <= REG_WDATA_I[23:0];
      end
      if (REG_WR_I && REG_ADDR_I == `ADDR_WDOG) begin
        wdog_cnt <= REG_WDATA_I;
      end else if (wdog_cnt != 32'h0000_0000) begin
        wdog_cnt <= wdog_cnt - 32'h0000_0001;
      end
      if (pkt_bad) begin
        link_err <= 1'b1;
      end else if (REG_WR_I && REG_ADDR_I == `ADDR_STATUS && REG_WDATA_I[`ST_LINK_ERR]) begin
        link_err <= 1'b0;
      end
      sw_pwr <= wr_cmd && REG_WDATA_I[`CMD_PWR];
      sw_rst <= wr_cmd && REG_WDATA_I[`CMD_RST];
      BLANK_DISPLAY_O <= cfg[`CFG_BLANK] && !host_on;
      if (REG_RD_I) begin
        case (REG_ADDR_I)
          `ADDR_CFG:    REG_RDATA_O <= {24'h000000, cfg};
          `ADDR_BOOT:   REG_RDATA_O <= {24'h000000, boot_cfg};
          `ADDR_PULSE:  REG_RDATA_O <= {8'h00, pulse_len};
          `ADDR_WDOG:   REG_RDATA_O <= wdog_cnt;
          `ADDR_STATUS: REG_RDATA_O <= {28'h0000000, link_err, busy[1], busy[0], host_on};
          default:      REG_RDATA_O <= 32'h0000_0000;
        endcase
      end else begin
        REG_RDATA_O <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================================
  // Switch pulse channels: 0 power, 1 reset
  wire [1:0] req = {rst_req, pwr_req};
  wire [1:0] inv = {cfg[`CFG_RST_INV], cfg[`CFG_PWR_INV]};
  generate
    for (g = 0; g < 2; g = g + 1) begin : pch
      reg [23:0] cnt;
      reg        oe;
      reg        lvl;
      always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
          cnt <= 24'h000000;
          oe  <= 1'b0;
          lvl <= 1'b0;
        end else if (req[g] && !oe) begin
          cnt <= pulse_len;
          oe  <= 1'b1;
          lvl <= inv[g];
        end else if (oe) begin
          if (cnt <= 24'h000001) begin
            oe <= 1'b0;
          end
          cnt <= (cnt == 24'h000000) ? cnt : cnt - 24'h000001;
        end
      end
      assign busy[g] = oe;
    end
  endgenerate

  assign PWR_SW_O    = pch[0].lvl;
  assign PWR_SW_OE_O = pch[0].oe;
  assign RST_SW_O    = pch[1].lvl;
  assign RST_SW_OE_O = pch[1].oe;

endmodule // host_power_reset_control

// ===== rtl/host_pwr_map.vh
// Constants for the host power and reset control block
`ifndef HOST_PWR_MAP_VH
`define HOST_PWR_MAP_VH

// ==========================================================================
// Timing
`define CLK_HZ         200000000
`define BAUD_RATE      115200
`define BIT_CYC        (`CLK_HZ / `BAUD_RATE)
`define HALF_CYC       (`BIT_CYC / 2)
`define PULSE_RESET    24'h989680

// ==========================================================================
// Register byte addresses
`define ADDR_CFG       8'h00
`define ADDR_BOOT      8'h04
`define ADDR_PULSE     8'h08
`define ADDR_WDOG      8'h0c
`define ADDR_STATUS    8'h10
`define ADDR_CMD       8'h14

// ==========================================================================
// Configuration byte fields
`define CFG_RESET      8'h00
`define CFG_PWR_INV    0
`define CFG_RST_INV    1
`define CFG_KEY_RST    4
`define CFG_KEY_ON     5
`define CFG_KEY_OFF    6
`define CFG_BLANK      7

// ==========================================================================
// Status and command fields
`define ST_HOST_ON     0
`define ST_PWR_BUSY    1
`define ST_RST_BUSY    2
`define ST_LINK_ERR    3
`define CMD_PWR        0
`define CMD_RST        1

// ==========================================================================
// Packet format
`define CMD_STORE      6'h04
`define CMD_ATX        6'h1c
`define TYPE_CMD       2'b00
`define TYPE_RESP      2'b01
`define TYPE_ERR       2'b11
`define MAX_LEN        8'h16
`define CRC_INIT       16'hffff
`define CRC_POLY       16'h8408
`define SYNC_RESET     4'h8

`endif

// ===== testbench/host_board.sv
// Host motherboard switch inputs and switched supply
module host_board (
  // Clock
  input  wire       clk_i,
  // Switch lines from the block
  input  wire       pwr_sw_i,
  input  wire       pwr_oe_i,
  input  wire       rst_sw_i,
  input  wire       rst_oe_i,
  // Supply sense and reset tally
  output reg        host_on_o,
  output reg  [7:0] resets_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Switch inputs are pulled up and pressed when driven low
  wire pwr_line = pwr_oe_i ? pwr_sw_i : 1'b1;
  wire rst_line = rst_oe_i ? rst_sw_i : 1'b1;
  reg  pwr_q;
  reg  rst_q;
  initial begin
    host_on_o = 1'b0;
    resets_o = 8'h0;
    pwr_q = 1'b1;
    rst_q = 1'b1;
  end
  always @(posedge clk_i) begin
    pwr_q <= pwr_line;
    rst_q <= rst_line;
    if (pwr_line && !pwr_q) host_on_o <= !host_on_o;
    if (rst_line && !rst_q) resets_o <= resets_o + 8'h1;
  end
endmodule // host_board

// ===== testbench/pwr_checker.sv
// Port assertions for the host power and reset control block
`include "host_pwr_map.vh"
module pwr_checker (
  // Clock and reset
  input wire        CORE_CLK_I,
  input wire        ARST_N_I,
  // Register port
  input wire [7:0]  REG_ADDR_I,
  input wire [31:0] REG_WDATA_I,
  input wire        REG_WR_I,
  input wire        REG_RD_I,
  input wire [31:0] REG_RDATA_O,
  // Host side
  input wire        HOST_PWR_SENSE_I,
  input wire        PWR_SW_O,
  input wire        PWR_SW_OE_O,
  input wire        RST_SW_O,
  input wire        RST_SW_OE_O,
  input wire        BLANK_DISPLAY_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  // ==========================================================================
  // Pulse length shadow and drive width counters
  reg  [23:0] plen;
  reg  [24:0] pcnt;
  reg  [24:0] rcnt;
  wire [24:0] want = (plen == 24'h0) ? 25'h1 : {1'b0, plen};
  always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      plen <= `PULSE_RESET;
      pcnt <= 25'h0;
      rcnt <= 25'h0;
    end else begin
      if (REG_WR_I && REG_ADDR_I == `ADDR_PULSE) plen <= REG_WDATA_I[23:0];
      pcnt <= PWR_SW_OE_O ? pcnt + 25'h1 : 25'h0;
      rcnt <= RST_SW_OE_O ? rcnt + 25'h1 : 25'h0;
    end
  end
  // ==========================================================================
  // Properties
  property p_rd_idle; !REG_RD_I |=> REG_RDATA_O == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_unmapped; REG_RD_I && REG_ADDR_I == 8'h18 |=> REG_RDATA_O == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_pwr_cmd;
    REG_WR_I && REG_ADDR_I == `ADDR_CMD && REG_WDATA_I[0] && !PWR_SW_OE_O |-> ##2 PWR_SW_OE_O;
  endproperty
  a_pwr_cmd: assert property (p_pwr_cmd) else $error("power pulse missing");
  property p_rst_cmd;
    REG_WR_I && REG_ADDR_I == `ADDR_CMD && REG_WDATA_I[1] && !RST_SW_OE_O |-> ##2 RST_SW_OE_O;
  endproperty
  a_rst_cmd: assert property (p_rst_cmd) else $error("reset pulse missing");
  property p_pwr_hold; PWR_SW_OE_O && $past(PWR_SW_OE_O) |-> $stable(PWR_SW_O); endproperty
  a_pwr_hold: assert property (p_pwr_hold) else $error("power level moved in pulse");
  property p_rst_hold; RST_SW_OE_O && $past(RST_SW_OE_O) |-> $stable(RST_SW_O); endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset level moved in pulse");
  property p_pwr_len; $fell(PWR_SW_OE_O) |-> pcnt == want; endproperty
  a_pwr_len: assert property (p_pwr_len) else $error("power pulse width wrong");
  property p_rst_len; $fell(RST_SW_OE_O) |-> rcnt == want; endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse width wrong");
  property p_wdog;
    REG_WR_I && REG_ADDR_I == `ADDR_WDOG && REG_WDATA_I == 32'h8 && !RST_SW_OE_O |-> ##[6:12] RST_SW_OE_O;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog pulse missing");
  property p_blank; HOST_PWR_SENSE_I [*8] |=> !BLANK_DISPLAY_O; endproperty
  a_blank: assert property (p_blank) else $error("blank while host up");
  property p_sense;
    HOST_PWR_SENSE_I [*8] ##0 (REG_RD_I && REG_ADDR_I == `ADDR_STATUS) |=> REG_RDATA_O[`ST_HOST_ON];
  endproperty
  a_sense: assert property (p_sense) else $error("host on not reported");
endmodule // pwr_checker

bind host_power_reset_control pwr_checker i_chk (.CORE_CLK_I, .ARST_N_I, .REG_ADDR_I, .REG_WDATA_I,
  .REG_WR_I, .REG_RD_I, .REG_RDATA_O, .HOST_PWR_SENSE_I, .PWR_SW_O, .PWR_SW_OE_O, .RST_SW_O,
  .RST_SW_OE_O, .BLANK_DISPLAY_O);

// ===== testbench/testbench.sv
// Self-checking bench for the host power and reset control block
`include "host_pwr_map.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  reg         clk = 1'b0;
  reg         arst_n, wr, rd, rxd, kpwr, krst;
  reg  [7:0]  addr;
  reg  [31:0] wdata;
  wire [31:0] rdata;
  wire        txd, psw, poe, rsw, roe, blank, host_on;
  wire [7:0]  resets;
  int         mismatches = 0;
  int         tests_run = 0;
  int         i, n;
  logic       lv;
  logic [15:0] crc;
  typedef struct {logic [7:0] cfg; logic [1:0] cmd; logic [23:0] len;} row_t;
  row_t rows[4] = '{'{8'h00, 2'h1, 24'h4}, '{8'h01, 2'h1, 24'h1}, '{8'h02, 2'h2, 24'h0},
                    '{8'h01, 2'h2, 24'h3}};
  always #2.5 clk = ~clk;
  host_power_reset_control i_dut (.CORE_CLK_I(clk), .ARST_N_I(arst_n), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .SER_RXD_I(rxd),
    .SER_TXD_O(txd), .KEY_POWER_I(kpwr), .KEY_RESET_I(krst), .HOST_PWR_SENSE_I(host_on),
    .PWR_SW_O(psw), .PWR_SW_OE_O(poe), .RST_SW_O(rsw), .RST_SW_OE_O(roe), .BLANK_DISPLAY_O(blank));
  host_board i_host (.clk_i(clk), .pwr_sw_i(psw), .pwr_oe_i(poe), .rst_sw_i(rsw), .rst_oe_i(roe),
    .host_on_o(host_on), .resets_o(resets));
  // ==========================================================================
  // Tasks
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr_reg(input [7:0] a, input [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task rd_reg(input [7:0] a, input [31:0] exp, input string what);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(what, exp, rdata);
    @(posedge clk);
  endtask
  task pulse(input bit r);
    int k;
    k = 0;
    n = 0;
    #1;
    while ((r ? roe : poe) !== 1'b1 && k < 60) begin
      @(posedge clk);
      #1;
      k++;
    end
    lv = r ? rsw : psw;
    while ((r ? roe : poe) === 1'b1 && n < 100) begin
      n++;
      @(posedge clk);
      #1;
    end
    repeat (3) @(posedge clk);
  endtask
  task key(input bit r);
    if (r) krst <= 1'b1;
    else kpwr <= 1'b1;
    pulse(r);
    krst <= 1'b0;
    kpwr <= 1'b0;
    repeat (20) @(posedge clk);
  endtask
  task tx_byte(input [7:0] b);
    for (int j = 0; j < 10; j++) begin
      rxd <= (j == 0) ? 1'b0 : (j == 9) ? 1'b1 : b[j - 1];
      repeat (`BIT_CYC) @(posedge clk);
    end
  endtask
  function automatic logic [15:0] crc_add(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========================================================================
  // Watchdog
  initial begin
    #600000;
    mismatches++;
    $display("CHECK FAILED watchdog expected end seen hang");
    stop_test;
  end
  // ==========================================================================
  // Main sequence
  initial begin
    {wr, rd, kpwr, krst, arst_n} = 5'h0;
    addr = 8'h0;
    wdata = 32'h0;
    rxd = 1'b1;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 4; i++) begin
      wr_reg(`ADDR_CFG, {24'h0, rows[i].cfg});
      wr_reg(`ADDR_PULSE, {8'h0, rows[i].len});
      rd_reg(`ADDR_PULSE, {8'h0, rows[i].len}, "pulse len");
      wr_reg(`ADDR_CMD, {30'h0, rows[i].cmd});
      pulse(rows[i].cmd[1]);
      chk("width", (rows[i].len == 0) ? 32'h1 : {8'h0, rows[i].len}, n);
      chk("level", {31'h0, rows[i].cfg[rows[i].cmd[1]]}, {31'h0, lv});
    end
    chk("host on", 32'h1, {31'h0, host_on});
    chk("resets", 32'h1, {24'h0, resets});
    $display("test rows done");
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd_reg(`ADDR_CFG, 32'h0, "cfg reset");
    rd_reg(`ADDR_BOOT, 32'h0, "boot reset");
    rd_reg(`ADDR_PULSE, {8'h0, `PULSE_RESET}, "pulse reset");
    rd_reg(`ADDR_WDOG, 32'h0, "wdog reset");
    rd_reg(`ADDR_STATUS, 32'h1, "status host on");
    wr_reg(`ADDR_BOOT, 32'hff);
    rd_reg(`ADDR_BOOT, 32'h0, "boot read only");
    rd_reg(8'h18, 32'h0, "unmapped");
    $display("test reset done");
    wr_reg(`ADDR_PULSE, 32'h2);
    wr_reg(`ADDR_WDOG, 32'h8);
    pulse(1'b1);
    chk("wdog width", 32'h2, n);
    chk("wdog resets", 32'h2, {24'h0, resets});
    $display("test watchdog done");
    wr_reg(`ADDR_CFG, 32'hf0);
    wr_reg(`ADDR_PULSE, 32'h3);
    key(1'b0);
    chk("key width", 32'h3, n);
    chk("key off", 32'h0, {31'h0, host_on});
    chk("blank", 32'h1, {31'h0, blank});
    key(1'b0);
    chk("key on", 32'h1, {31'h0, host_on});
    chk("unblank", 32'h0, {31'h0, blank});
    key(1'b1);
    chk("key reset", 32'h3, {24'h0, resets});
    $display("test keypad done");
    tx_byte(8'h1c);
    tx_byte(8'h17);
    repeat (20) @(posedge clk);
    rd_reg(`ADDR_STATUS, 32'h9, "link error");
    chk("no reply", 32'h1, {31'h0, txd});
    wr_reg(`ADDR_STATUS, 32'h8);
    rd_reg(`ADDR_STATUS, 32'h1, "error cleared");
    $display("test link done");
    crc = ~crc_add(crc_add(`CRC_INIT, 8'h04), 8'h00);
    tx_byte(8'h04);
    tx_byte(8'h00);
    tx_byte(crc[7:0]);
    tx_byte(crc[15:8]);
    chk("reply start", 32'h0, {31'h0, txd});
    rd_reg(`ADDR_BOOT, 32'hf0, "boot stored");
    $display("test store done");
    stop_test;
  end
endmodule // testbench
